//--- lcap_regs.sv
// link capabilities register bank with link-control clock bit and unlock control
//
// Operation
// - speed field read-only four bits, resets to 1 meaning 2.5 Gbps
// - upstream port accepts a width override to force narrower link
// - invalid or reserved width encoding runs the link at one lane
// - width field loads the port's built width at hardware initialisation
// - widths 1, 2, 4 valid; all other encodings reserved
// - low-power support field hardwired to 3, both states supported
// - separate reference clocks give L0s exit latency code 5
// - common reference clock gives L0s exit latency code 3
// - common-clock selection comes from the link control clock bit
// - L1 exit latency field defaults to 2
// - reference clock removal bit defaults to zero
// - surprise-down bit one downstream, zero and kept zero upstream
// - link-active reporting bit one downstream, zero upstream
// - top byte read-only, holds the port's own number
`default_nettype none
module lcap_regs
   import lcap_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [11:0] addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic        strap_upstream_in,
   input  wire logic [5:0]  strap_width_in,
   input  wire logic [7:0]  strap_port_id_in,
   output logic      [31:0] rd_data_out,
   output logic      [5:0]  lane_width_out,
   output logic             shared_refclk_out,
   output logic             init_done_out
);
   ////////////////////////////////////////////////////////////////////////
   // strap synchronisation
   lcap_strap_s strap_raw;
   lcap_strap_s strap_sync;
   logic        strap_agree;

   assign strap_raw = '{upstream: strap_upstream_in, width: strap_width_in, port_id: strap_port_id_in};

   lcap_sync3 #(
      .W ($bits(lcap_strap_s))
   ) u_strap_sync (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .d_in      (strap_raw),
      .q_out     (strap_sync),
      .agree_out (strap_agree)
   );

   ////////////////////////////////////////////////////////////////////////
   // state
   lcap_state_e state;
   lcap_state_e next_state;
   logic [1:0]  fill_cnt;
   logic [1:0]  next_fill_cnt;
   logic        upstream;
   logic        next_upstream;
   logic [7:0]  port_id;
   logic [7:0]  next_port_id;
   logic [5:0]  width;
   logic [5:0]  next_width;
   logic [2:0]  l1_lat;
   logic [2:0]  next_l1_lat;
   logic        refclk_rm;
   logic        next_refclk_rm;
   logic        sdown;
   logic        next_sdown;
   logic        lactive;
   logic        next_lactive;
   logic        shared_refclk_select;
   logic        next_shared_refclk_select;
   logic        unlock;
   logic        next_unlock;
   logic [31:0] next_rd_data;
   logic [5:0]  next_lane_width;
   logic        next_init_done;
   lcap_word_s  cap_word;
   lcap_word_s  wr_word;
   logic        cap_wr;

   assign wr_word = lcap_word_s'(wr_data_in);
   // unlock-writable fields take a write only when software has opened them and the bank is in run; strap load sets width too
   assign cap_wr  = wr_in && (addr_in == LCAP_CAP_OFS) && unlock && (state == LCAP_ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // assembled capabilities word
   always_comb begin
      cap_word                              = '0;
      cap_word.max_speed_field              = LCAP_SPEED_RST;
      cap_word.max_width_field              = width;
      cap_word.low_power_support_field      = LCAP_LOWPWR_RST;
      // latency tracks the clock mode bit live, so no write can make it lie
      cap_word.l0s_exit_latency_field       = shared_refclk_select ? LCAP_L0S_COMMON : LCAP_L0S_SEP;
      cap_word.l1_exit_latency_field        = l1_lat;
      cap_word.refclk_removal_capable       = refclk_rm;
      cap_word.surprise_down_report_capable = sdown;
      cap_word.link_active_report_capable   = lactive;
      cap_word.rsvd                         = LCAP_RSVD_VAL;
      cap_word.port_id_field                = port_id;
   end

   ////////////////////////////////////////////////////////////////////////
   // next-state logic for init sequence, fields and read path
   always_comb begin
      next_state      = state;
      next_fill_cnt   = fill_cnt;
      next_upstream   = upstream;
      next_port_id    = port_id;
      next_width      = width;
      next_l1_lat     = l1_lat;
      next_refclk_rm  = refclk_rm;
      next_sdown      = sdown;
      next_lactive    = lactive;
      next_shared_refclk_select       = shared_refclk_select;
      next_unlock     = unlock;
      next_rd_data    = 32'h0000_0000;
      next_init_done  = (state == LCAP_ST_RUN);
      case (state)
         LCAP_ST_SYNC: begin
            // wait until the synchroniser holds real strap values
            if (fill_cnt == LCAP_SYNC_FILL) begin
               next_state = LCAP_ST_LOAD;
            end else begin
               next_fill_cnt = fill_cnt + 2'h1;
            end
         end
         LCAP_ST_LOAD: begin
            if (strap_agree) begin
               next_upstream = strap_sync.upstream;
               next_port_id  = strap_sync.port_id;
               next_width    = strap_sync.width;
               next_sdown    = strap_sync.upstream ? 1'b0 : LCAP_DOWN_CAP;
               next_lactive  = strap_sync.upstream ? 1'b0 : LCAP_DOWN_CAP;
               next_state    = LCAP_ST_RUN;
            end
         end
         LCAP_ST_RUN: begin
            if (cap_wr) begin
               // narrowing is an upstream-only feature
               if (upstream) begin
                  next_width = wr_word.max_width_field;
               end
               next_l1_lat    = wr_word.l1_exit_latency_field;
               next_refclk_rm = wr_word.refclk_removal_capable;
               // upstream keeps both reporting bits at zero whatever is written
               next_sdown     = upstream ? 1'b0 : wr_word.surprise_down_report_capable;
               next_lactive   = upstream ? 1'b0 : wr_word.link_active_report_capable;
            end
         end
         default: begin
            next_state = LCAP_ST_SYNC;
         end
      endcase
      // control registers answer in every state
      if (wr_in) begin
         if (addr_in == LCAP_CTL_OFS) begin
            next_shared_refclk_select = wr_data_in[LCAP_SHARED_REFCLK_SELECT_BIT];
         end else if (addr_in == LCAP_UNLOCK_OFS) begin
            next_unlock = wr_data_in[LCAP_UNLOCK_BIT];
         end
      end
      // read data in the following cycle only; unmapped reads give zero
      if (rd_in) begin
         if (addr_in == LCAP_CAP_OFS) begin
            next_rd_data = cap_word;
         end else if (addr_in == LCAP_CTL_OFS) begin
            next_rd_data[LCAP_SHARED_REFCLK_SELECT_BIT] = shared_refclk_select;
         end else if (addr_in == LCAP_UNLOCK_OFS) begin
            next_rd_data[LCAP_UNLOCK_BIT] = unlock;
         end
      end
      next_lane_width = lcap_eff_width(width);
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state             <= LCAP_ST_SYNC;
         fill_cnt          <= 2'h0;
         upstream          <= 1'b1;
         port_id           <= LCAP_PORT_RST;
         width             <= LCAP_WIDTH_X1;
         l1_lat            <= LCAP_L1_RST;
         refclk_rm         <= LCAP_REFCLK_RST;
         sdown             <= 1'b0;
         lactive           <= 1'b0;
         shared_refclk_select              <= LCAP_SHARED_REFCLK_SELECT_RST;
         unlock            <= LCAP_UNLOCK_RST;
         rd_data_out       <= 32'h0000_0000;
         lane_width_out    <= LCAP_WIDTH_X1;
         shared_refclk_out <= LCAP_SHARED_REFCLK_SELECT_RST;
         init_done_out     <= 1'b0;
      end else begin
         state             <= next_state;
         fill_cnt          <= next_fill_cnt;
         upstream          <= next_upstream;
         port_id           <= next_port_id;
         width             <= next_width;
         l1_lat            <= next_l1_lat;
         refclk_rm         <= next_refclk_rm;
         sdown             <= next_sdown;
         lactive           <= next_lactive;
         shared_refclk_select              <= next_shared_refclk_select;
         unlock            <= next_unlock;
         rd_data_out       <= next_rd_data;
         lane_width_out    <= next_lane_width;
         shared_refclk_out <= next_shared_refclk_select;
         init_done_out     <= next_init_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // read strobe for the capabilities word, shared by the checks below
   logic cap_rd;
   assign cap_rd = rd_in && (addr_in == LCAP_CAP_OFS);

   AST_SPEED: assert property (cap_rd |=> rd_data_out[3:0] == 4'h1)
      else $error("speed field not 1");
   AST_OVERRIDE: assert property (cap_wr && upstream && (lcap_eff_width(wr_data_in[9:4]) == wr_data_in[9:4])
                                  |-> ##2 lane_width_out == $past(wr_data_in[9:4], 2))
      else $error("upstream width override not applied");
   AST_X1_FALLBACK: assert property ((width != 6'h01) && (width != 6'h02) && (width != 6'h04)
                                     |=> lane_width_out == 6'h01)
      else $error("reserved width not run as one lane");
   AST_HWINIT: assert property ((state == LCAP_ST_LOAD) && strap_agree |=> width == $past(strap_sync.width))
      else $error("built width not loaded");
   AST_LEGAL_WIDTH: assert property (lane_width_out inside {6'h01, 6'h02, 6'h04})
      else $error("lane width not 1, 2 or 4");
   AST_LOWPWR: assert property (cap_rd |=> rd_data_out[11:10] == 2'h3)
      else $error("low power support not 3");
   AST_L0S_SEP: assert property (cap_rd && !shared_refclk_select |=> rd_data_out[14:12] == 3'h5)
      else $error("separate clock latency not 5");
   AST_L0S_COMMON: assert property (cap_rd && shared_refclk_select |=> rd_data_out[14:12] == 3'h3)
      else $error("common clock latency not 3");
   AST_SHARED_REFCLK_SELECT_SEL: assert property (wr_in && (addr_in == LCAP_CTL_OFS) |=> shared_refclk_out == $past(wr_data_in[6]))
      else $error("clock mode bit not taken");
   AST_UP_ZERO: assert property (cap_rd && upstream |=> rd_data_out[20:19] == 2'h0)
      else $error("upstream reporting bits not zero");
   AST_RSVD: assert property (rd_in |=> rd_data_out[23:21] == 3'h0)
      else $error("reserved bits not zero");
   AST_PORT_ID: assert property (cap_rd |=> rd_data_out[31:24] == $past(port_id))
      else $error("port number wrong");
   AST_LOCKED: assert property (wr_in && (addr_in == LCAP_CAP_OFS) && !unlock && (state != LCAP_ST_LOAD)
                                |=> $stable(width) && $stable(l1_lat) && $stable(refclk_rm)
                                    && $stable(sdown) && $stable(lactive))
      else $error("locked field changed on write");
   AST_RD_GAP: assert property (!rd_in |=> rd_data_out == 32'h0000_0000)
      else $error("read data outside its cycle");

   // strap capture and the per-port defaults that it sets
   AST_DOWN_LOAD: assert property ((state == LCAP_ST_LOAD) && strap_agree && !strap_sync.upstream
                                   |=> sdown && lactive)
      else $error("downstream reporting bits not set at load");
   AST_PORT_HOLD: assert property ((state == LCAP_ST_RUN) |=> $stable(port_id))
      else $error("port number moved after load");
   AST_UP_BITS: assert property (upstream && (state == LCAP_ST_RUN) |-> !sdown && !lactive)
      else $error("upstream reporting bit set");
   AST_INIT_DONE: assert property ((state == LCAP_ST_RUN) |=> init_done_out)
      else $error("init done not raised in run");

   // write side: what may move and what must not
   AST_DOWN_NO_WIDTH: assert property (cap_wr && !upstream |=> $stable(width))
      else $error("downstream width took a write");
   AST_UNLOCK_WR: assert property (wr_in && (addr_in == LCAP_UNLOCK_OFS)
                                   |=> unlock == $past(wr_data_in[0]))
      else $error("unlock bit not taken");
   AST_L1_WR: assert property (cap_wr |=> l1_lat == $past(wr_data_in[17:15]))
      else $error("unlocked latency write not taken");
   AST_REFCLK_WR: assert property (cap_wr |=> refclk_rm == $past(wr_data_in[18]))
      else $error("unlocked clock removal write not taken");
   AST_SHARED_REFCLK_SELECT_HOLD: assert property (!(wr_in && (addr_in == LCAP_CTL_OFS)) |=> $stable(shared_refclk_select))
      else $error("clock mode bit moved without a write");

   // read side and lane width: legal widths pass through unchanged
   AST_LEGAL_PASS: assert property ((width == LCAP_WIDTH_X1) || (width == LCAP_WIDTH_X2) || (width == LCAP_WIDTH_X4)
                                    |=> lane_width_out == $past(width))
      else $error("legal width not passed to the lanes");
   AST_UNMAPPED_RD: assert property (rd_in && (addr_in != LCAP_CAP_OFS) && (addr_in != LCAP_CTL_OFS)
                                     && (addr_in != LCAP_UNLOCK_OFS) |=> rd_data_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_CTL_RD: assert property (rd_in && (addr_in == LCAP_CTL_OFS)
                                |=> rd_data_out == {25'h0, $past(shared_refclk_select), 6'h00})
      else $error("link control read wrong");

   COV_OVERRIDE: cover property (cap_wr && upstream ##2 lane_width_out != $past(width, 2));
   COV_COMMON: cover property (cap_rd && shared_refclk_select);
   COV_DOWN_RD: cover property (cap_rd && !upstream && (state == LCAP_ST_RUN));
   COV_LOCKED_WR: cover property (wr_in && (addr_in == LCAP_CAP_OFS) && !unlock);
   COV_RSVD_WIDTH: cover property ((state == LCAP_ST_RUN) && (lane_width_out != width));
endmodule // lcap_regs
`default_nettype wire

//--- lcap_pkg.sv
// constants, types and helpers for the link capabilities register bank
`default_nettype none
package lcap_pkg;
   // register byte addresses
   localparam logic [11:0] LCAP_CAP_OFS      = 12'h04c;
   localparam logic [11:0] LCAP_CTL_OFS      = 12'h050;
   localparam logic [11:0] LCAP_UNLOCK_OFS   = 12'h100;
   // bit positions
   localparam int          LCAP_SHARED_REFCLK_SELECT_BIT     = 6;
   localparam int          LCAP_UNLOCK_BIT   = 0;
   // field values and reset values
   localparam logic [3:0]  LCAP_SPEED_RST    = 4'h1;
   localparam logic [3:0]  LCAP_SPEED_GEN2   = 4'h2;
   localparam logic [5:0]  LCAP_WIDTH_X1     = 6'h01;
   localparam logic [5:0]  LCAP_WIDTH_X2     = 6'h02;
   localparam logic [5:0]  LCAP_WIDTH_X4     = 6'h04;
   localparam logic [1:0]  LCAP_LOWPWR_RST   = 2'h3;
   localparam logic [2:0]  LCAP_L0S_SEP      = 3'h5;
   localparam logic [2:0]  LCAP_L0S_COMMON   = 3'h3;
   localparam logic [2:0]  LCAP_L1_RST       = 3'h2;
   localparam logic        LCAP_REFCLK_RST   = 1'h0;
   localparam logic        LCAP_DOWN_CAP     = 1'h1;
   localparam logic [7:0]  LCAP_PORT_RST     = 8'h00;
   localparam logic [2:0]  LCAP_RSVD_VAL     = 3'h0;
   localparam logic        LCAP_SHARED_REFCLK_SELECT_RST     = 1'h0;
   localparam logic        LCAP_UNLOCK_RST   = 1'h0;
   // strap synchroniser fill time in cycles
   localparam logic [1:0]  LCAP_SYNC_FILL    = 2'h3;

   // layout of the capabilities word, msb first
   typedef struct packed {
      logic [7:0] port_id_field;
      logic [2:0] rsvd;
      logic       link_active_report_capable;
      logic       surprise_down_report_capable;
      logic       refclk_removal_capable;
      logic [2:0] l1_exit_latency_field;
      logic [2:0] l0s_exit_latency_field;
      logic [1:0] low_power_support_field;
      logic [5:0] max_width_field;
      logic [3:0] max_speed_field;
   } lcap_word_s;

   // per-port build straps
   typedef struct packed {
      logic       upstream;
      logic [5:0] width;
      logic [7:0] port_id;
   } lcap_strap_s;

   typedef enum logic [2:0] {
      LCAP_ST_SYNC = 3'b001,
      LCAP_ST_LOAD = 3'b010,
      LCAP_ST_RUN  = 3'b100
   } lcap_state_e;

   // legal widths pass, anything else falls back to one lane
   function automatic logic [5:0] lcap_eff_width(input logic [5:0] w);
      if ((w == LCAP_WIDTH_X1) || (w == LCAP_WIDTH_X2) || (w == LCAP_WIDTH_X4)) begin
         return w;
      end
      return LCAP_WIDTH_X1;
   endfunction
endpackage
`default_nettype wire

//--- lcap_sync3.sv
// three-stage synchroniser with an agreement flag for static straps
`default_nettype none
module lcap_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out,
   output logic              agree_out
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // stage1 is only ever read by stage2
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= d_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a value counts once the last two stages agree
   assign q_out     = stage3;
   assign agree_out = (stage2 == stage3);
endmodule // lcap_sync3
`default_nettype wire

//--- lcap_tb.sv
// self-checking testbench for the link capabilities register bank
`default_nettype none
module testbench
   import lcap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // one strap setting per row, with the lane width it must give
   typedef struct packed {
      logic       up;
      logic [5:0] width;
      logic [7:0] id;
      logic [5:0] lane;
   } lcap_row_s;

   logic        clk_in            = 1'b0;
   logic        rst_b_in          = 1'b0;
   logic [11:0] addr_in           = 12'h000;
   logic [31:0] wr_data_in        = 32'h0000_0000;
   logic        wr_in             = 1'b0;
   logic        rd_in             = 1'b0;
   logic        strap_upstream_in = 1'b0;
   logic [5:0]  strap_width_in    = 6'h01;
   logic [7:0]  strap_port_id_in  = 8'h00;
   logic [31:0] rd_data_out;
   logic [5:0]  lane_width_out;
   logic        shared_refclk_out;
   logic        init_done_out;
   int          n_fail            = 0;
   int          n_tests           = 0;
   logic [31:0] rd_val;
   logic [31:0] wd;
   lcap_row_s   rows [5]          = '{'{1'b1, 6'h04, 8'h00, 6'h04}, '{1'b0, 6'h02, 8'h02, 6'h02},
                                      '{1'b0, 6'h01, 8'h03, 6'h01}, '{1'b0, 6'h08, 8'h04, 6'h01},
                                      '{1'b0, 6'h00, 8'h05, 6'h01}};

   ////////////////////////////////////////////////////////////////////////////
   lcap_regs dut (
      .clk_in            (clk_in),
      .rst_b_in          (rst_b_in),
      .addr_in           (addr_in),
      .wr_data_in        (wr_data_in),
      .wr_in             (wr_in),
      .rd_in             (rd_in),
      .strap_upstream_in (strap_upstream_in),
      .strap_width_in    (strap_width_in),
      .strap_port_id_in  (strap_port_id_in),
      .rd_data_out       (rd_data_out),
      .lane_width_out    (lane_width_out),
      .shared_refclk_out (shared_refclk_out),
      .init_done_out     (init_done_out)
   );

   // 4 ns period
   always #2 clk_in = ~clk_in;

   ////////////////////////////////////////////////////////////////////////////
   // expected capabilities word built field by field
   function automatic logic [31:0] exp_word(input logic up, input logic [5:0] w, input logic [7:0] id,
                                            input logic shared_refclk_select);
      return {id, 3'h0, ~up, ~up, 1'b0, 3'h2, (shared_refclk_select ? 3'h3 : 3'h5), 2'h3, w, 4'h1};
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if ((n_fail == 0) && (n_tests > 0)) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   // single-cycle strobes, changed just after the edge
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_in      <= 1'b1;
      @(posedge clk_in);
      wr_in      <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 d = rd_data_out;
   endtask

   // reset with new straps, then wait a bounded time for the load
   task automatic start(input logic up, input logic [5:0] w, input logic [7:0] id);
      int k;
      @(posedge clk_in);
      rst_b_in          <= 1'b0;
      strap_upstream_in <= up;
      strap_width_in    <= w;
      strap_port_id_in  <= id;
      repeat (12) @(posedge clk_in);
      #1 chk_bit("init done in reset", 1'b0, init_done_out);
      chk_word("read data in reset", 32'h0, rd_data_out);
      chk_word("lane width in reset", 32'h1, {26'h0, lane_width_out});
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      for (k = 0; (k < 50) && (init_done_out !== 1'b1); k++) begin
         @(posedge clk_in);
         #1;
      end
      if (init_done_out !== 1'b1) begin
         n_fail++;
         $display("Error init done expected 1 seen %b", init_done_out);
         close_out();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // table of strap rows, then hand-written override cases
   initial begin
      for (int i = 0; i < 5; i++) begin
         start(rows[i].up, rows[i].width, rows[i].id);
         bus_rd(LCAP_CAP_OFS, rd_val);
         chk_word("cap word", exp_word(rows[i].up, rows[i].width, rows[i].id, 1'b0), rd_val);
         chk_word("lane width", {26'h0, rows[i].lane}, {26'h0, lane_width_out});
         bus_wr(LCAP_CTL_OFS, 32'h0000_0040);
         bus_rd(LCAP_CAP_OFS, rd_val);
         chk_word("cap common clock", exp_word(rows[i].up, rows[i].width, rows[i].id, 1'b1), rd_val);
         chk_bit("shared refclk", 1'b1, shared_refclk_out);
         bus_wr(LCAP_CAP_OFS, 32'h0000_0000);
         bus_rd(LCAP_CAP_OFS, rd_val);
         chk_word("cap locked write", exp_word(rows[i].up, rows[i].width, rows[i].id, 1'b1), rd_val);
         bus_wr(LCAP_CTL_OFS, 32'h0000_0000);
         bus_rd(LCAP_CAP_OFS, rd_val);
         chk_word("cap separate clock", exp_word(rows[i].up, rows[i].width, rows[i].id, 1'b0), rd_val);
         $display("row %0d done", i);
      end
      // upstream override; l1 and clock-removal bits written with their reset values
      start(1'b1, 6'h04, 8'h00);
      wd = {8'hff, 3'h7, 2'h3, 1'b0, 3'h2, 3'h0, 2'h0, 6'h3f, 4'hf};
      bus_wr(LCAP_UNLOCK_OFS, 32'h0000_0001);
      bus_wr(LCAP_CAP_OFS, wd);
      bus_rd(LCAP_CAP_OFS, rd_val);
      chk_word("cap reserved width", exp_word(1'b1, 6'h3f, 8'h00, 1'b0), rd_val);
      chk_word("lane reserved width", 32'h1, {26'h0, lane_width_out});
      @(posedge clk_in);
      #1 chk_word("read data after one cycle", 32'h0, rd_data_out);
      bus_wr(LCAP_CAP_OFS, {wd[31:10], 6'h02, wd[3:0]});
      repeat (2) @(posedge clk_in);
      #1 chk_word("lane narrowed", 32'h2, {26'h0, lane_width_out});
      bus_rd(12'h0f0, rd_val);
      chk_word("unmapped read", 32'h0, rd_val);
      bus_wr(12'h0f0, 32'hffff_ffff);
      bus_wr(LCAP_UNLOCK_OFS, 32'h0000_0000);
      bus_wr(LCAP_CAP_OFS, {wd[31:10], 6'h01, wd[3:0]});
      bus_rd(LCAP_CAP_OFS, rd_val);
      chk_word("cap relocked", exp_word(1'b1, 6'h02, 8'h00, 1'b0), rd_val);
      $display("override test done");
      // downstream port: width write refused, reporting bits writable once unlocked
      start(1'b0, 6'h02, 8'h03);
      bus_wr(LCAP_UNLOCK_OFS, 32'h0000_0001);
      bus_wr(LCAP_CAP_OFS, 32'h0001_0040);
      bus_rd(LCAP_CAP_OFS, rd_val);
      chk_word("cap downstream write", exp_word(1'b0, 6'h02, 8'h03, 1'b0) & 32'hffe7_ffff, rd_val);
      chk_word("lane downstream", 32'h2, {26'h0, lane_width_out});
      bus_wr(LCAP_CTL_OFS, 32'h0000_0040);
      bus_rd(LCAP_CTL_OFS, rd_val);
      chk_word("link control read", 32'h0000_0040, rd_val);
      $display("downstream test done");
      // a fresh reset drops the override and reloads the built width
      start(1'b1, 6'h04, 8'h00);
      bus_rd(LCAP_CAP_OFS, rd_val);
      chk_word("cap after reset", exp_word(1'b1, 6'h04, 8'h00, 1'b0), rd_val);
      chk_word("lane after reset", 32'h4, {26'h0, lane_width_out});
      $display("reset test done");
      close_out();
   end
endmodule // testbench
`default_nettype wire
